// ===== hmfs_map.svh
// Purpose: Offsets, field positions and reset values of the FIFO status bank
// Assumes: 8-bit byte addresses on AXI4-Lite, one 32-bit word per register
// Notes:   Definitions only
//
// Behaviour
// - Writing one to skip bit moves RX data read position to next frame.
// - Skip bit stays high while skipping and clears itself when done.
// - RX occupancy bits 23:16 show RX status FIFO words used.
// - TX occupancy bits 23:16 show TX status FIFO words used.
// - TX occupancy bits 15:0 show TX data bytes free, reset 1200h.
// - Dropped-frame counter adds one for every discarded receive frame.
// - Reading dropped-frame counter returns the count, then clears it.
// - Counter passing 7FFFFFFF to 80000000 sets halfway flag at bit 23.
// - Writing one to busy starts indirect access of selected MAC register.
// - Busy stays set until access ends; then read data is valid.
// - Direction bit 30: one reads the internal register, zero writes it.
// - Address field 7:0 selects the internal MAC control register.
// - Data register reads internal data for reads, else last written value.
`ifndef HMFS_MAP_SVH
`define HMFS_MAP_SVH
`define HMFS_OFS_RXCTL    8'h78
`define HMFS_OFS_RXOCC    8'h7C
`define HMFS_OFS_TXOCC    8'h80
`define HMFS_OFS_DROP     8'hA0
`define HMFS_OFS_CMD      8'hA4
`define HMFS_OFS_DATA     8'hA8
`define HMFS_OFS_INTSTS   8'hC0
`define HMFS_OFS_INTEN    8'hC4
`define HMFS_BIT_SKIP     31
`define HMFS_BIT_BUSY     31
`define HMFS_BIT_DIR      30
`define HMFS_BIT_HALF     23
`define HMFS_TX_DATA_BYTES_FREE_RST   16'h1200
`define HMFS_DROP_HALF    32'h7FFFFFFF
`define HMFS_WORD_BYTES   16'h0004
`define HMFS_WORD_ROUND   16'h0003
`define HMFS_WORD_MASK    16'hFFFC
`define HMFS_RESP_OKAY    2'h0
`define HMFS_RESP_SLVERR  2'h2
`endif

// ===== hmfs_pkg.sv
// Purpose: Types of the FIFO status bank
// Assumes: Constants live in hmfs_map.svh
// Notes:   State of each module is one packed struct
package hmfs_pkg;
  typedef enum logic [0:0] {ENG_IDLE = 1'b0, ENG_WAIT = 1'b1} hmfs_eng_e;

  typedef struct packed {
    hmfs_eng_e   state;
    logic        we;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } hmfs_eng_s;

  typedef struct packed {
    logic        awHeld;
    logic [7:0]  awAddr;
    logic        wHeld;
    logic [31:0] wData;
    logic [3:0]  wStrb;
    logic        bValid;
    logic [1:0]  bResp;
    logic        rValid;
    logic [31:0] rData;
    logic [1:0]  rResp;
    logic        skip;
    logic [15:0] rxUsed;
    logic [15:0] tx_data_bytes_free;
    logic [31:0] drops;
    logic        halfSts;
    logic        halfEn;
    logic        cmdDir;
    logic [7:0]  cmdAddr;
    logic        busy;
    logic [31:0] csrWr;
    logic [31:0] csrRd;
  } hmfs_regs_s;
endpackage : hmfs_pkg

// ===== hmfs_csr_if.sv
// Purpose: Link between register bank and indirect access engine
// Assumes: Single clock domain
// Notes:   start and done are one-cycle pulses
`timescale 1ns/10ps
`default_nettype none
interface hmfs_csr_if;
  logic        start;
  logic        isRead;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic        done;
  logic [31:0] rdata;
  modport regs   (output start, isRead, addr, wdata, input done, rdata);
  modport engine (input start, isRead, addr, wdata, output done, rdata);
endinterface : hmfs_csr_if
`default_nettype wire

// ===== hmfs_csr_engine.sv
// Purpose: Performs one indirect access to the MAC control registers
// Assumes: MAC answers each select with an acknowledge pulse
// Notes:   Read data passes through on the acknowledge cycle
`timescale 1ns/10ps
`default_nettype none
module hmfs_csr_engine (
  input  wire logic         clk_sys,      // System clock
  input  wire logic         rst,          // Async reset, active high
  hmfs_csr_if.engine        csrIf,        // Request from register bank
  output logic              macCsrSel,    // Access in progress
  output logic              macCsrWe,     // One for write
  output logic [7:0]        macCsrAddr,   // Target register index
  output logic [31:0]       macCsrWdata,  // Write data
  input  wire logic [31:0]  macCsrRdata,  // Read data
  input  wire logic         macCsrAck     // Access finished
);
  hmfs_pkg::hmfs_eng_s q;
  hmfs_pkg::hmfs_eng_s d;

  always_comb begin
    d = q;
    unique case (q.state)
      hmfs_pkg::ENG_IDLE: begin
        if (csrIf.start) begin
          d.state = hmfs_pkg::ENG_WAIT;
          d.we    = ~csrIf.isRead;
          d.addr  = csrIf.addr;
          d.wdata = csrIf.wdata;
        end
      end
      hmfs_pkg::ENG_WAIT: begin
        if (macCsrAck) begin
          d.state = hmfs_pkg::ENG_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign macCsrSel   = (q.state == hmfs_pkg::ENG_WAIT);
  assign macCsrWe    = q.we;
  assign macCsrAddr  = q.addr;
  assign macCsrWdata = q.wdata;
  assign csrIf.done  = macCsrSel & macCsrAck;
  assign csrIf.rdata = macCsrRdata;
endmodule : hmfs_csr_engine
`default_nettype wire

// ===== hmfs_regs.sv
// Purpose: Host MAC FIFO status, dropped-frame and indirect access registers
// Assumes: AXI4-Lite slave, one write and one read outstanding
// Notes:   Unmapped addresses answer SLVERR and read zero
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "hmfs_map.svh"
`default_nettype none
module hmfs_regs (
  input  wire logic         clk_sys,          // System clock, 100 MHz
  input  wire logic         rst,              // Async reset, active high
  input  wire logic [7:0]   s_axi_awaddr,     // Write address
  input  wire logic         s_axi_awvalid,    // Write address valid
  output logic              s_axi_awready,    // Write address ready
  input  wire logic [31:0]  s_axi_wdata,      // Write data
  input  wire logic [3:0]   s_axi_wstrb,      // Write byte enables
  input  wire logic         s_axi_wvalid,     // Write data valid
  output logic              s_axi_wready,     // Write data ready
  output logic [1:0]        s_axi_bresp,      // Write response
  output logic              s_axi_bvalid,     // Write response valid
  input  wire logic         s_axi_bready,     // Write response ready
  input  wire logic [7:0]   s_axi_araddr,     // Read address
  input  wire logic         s_axi_arvalid,    // Read address valid
  output logic              s_axi_arready,    // Read address ready
  output logic [31:0]       s_axi_rdata,      // Read data
  output logic [1:0]        s_axi_rresp,      // Read response
  output logic              s_axi_rvalid,     // Read data valid
  input  wire logic         s_axi_rready,     // Read data ready
  input  wire logic         rxFrameDone,      // Frame written to RX data
  input  wire logic [15:0]  rxFrameLen,       // Its length in bytes
  input  wire logic         rxDataPop,        // One RX data word read
  output logic              rxSkipReq,        // Skip to next frame
  input  wire logic         rxSkipDone,       // Skip finished
  input  wire logic [15:0]  rxSkipBytes,      // Bytes removed by skip
  input  wire logic [7:0]   rxStatusWordsUsed, // RX status words
  input  wire logic [7:0]   txStatusWordsUsed, // TX status words
  input  wire logic         txDataPush,       // One TX data word written
  input  wire logic         txDataRelease,    // TX bytes freed
  input  wire logic [15:0]  txReleaseBytes,   // Count of bytes freed
  input  wire logic         rxFrameDropped,   // Frame discarded
  output logic              macCsrSel,        // Indirect access active
  output logic              macCsrWe,         // Indirect write
  output logic [7:0]        macCsrAddr,       // Indirect register index
  output logic [31:0]       macCsrWdata,      // Indirect write data
  input  wire logic [31:0]  macCsrRdata,      // Indirect read data
  input  wire logic         macCsrAck,        // Indirect access done
  output logic              irq               // Interrupt, active high
);
  localparam hmfs_pkg::hmfs_regs_s RST_VAL =
    '{tx_data_bytes_free: `HMFS_TX_DATA_BYTES_FREE_RST, default: '0};

  hmfs_pkg::hmfs_regs_s q;
  hmfs_pkg::hmfs_regs_s d;
  hmfs_csr_if csrIf ();

  logic [31:0] byteMask;
  logic [31:0] wdm;
  logic [7:0]  wrAddr;
  logic [7:0]  rdAddr;
  logic        wrFire;
  logic        rdFire;
  logic        rdDrop;
  logic        cmdWr;
  logic        dataWr;
  logic [15:0] rxAdd;

  // ==========================================================
  // Bus handshake
  assign s_axi_awready = ~q.awHeld;
  assign s_axi_wready  = ~q.wHeld;
  assign s_axi_bvalid  = q.bValid;
  assign s_axi_bresp   = q.bResp;
  assign s_axi_arready = ~q.rValid;
  assign s_axi_rvalid  = q.rValid;
  assign s_axi_rdata   = q.rData;
  assign s_axi_rresp   = q.rResp;

  assign byteMask = {{8{q.wStrb[3]}}, {8{q.wStrb[2]}},
                     {8{q.wStrb[1]}}, {8{q.wStrb[0]}}};
  assign wdm      = q.wData & byteMask;
  assign wrAddr   = {q.awAddr[7:2], 2'b00};
  assign rdAddr   = {s_axi_araddr[7:2], 2'b00};
  assign wrFire   = q.awHeld & q.wHeld & ~q.bValid;
  assign rdFire   = s_axi_arvalid & ~q.rValid;
  assign rdDrop   = rdFire & (rdAddr == `HMFS_OFS_DROP);
  // Command and data frozen while busy
  assign cmdWr    = wrFire & (wrAddr == `HMFS_OFS_CMD) & ~q.busy;
  assign dataWr   = wrFire & (wrAddr == `HMFS_OFS_DATA) & ~q.busy;
  // Round length up to whole words
  assign rxAdd    = (rxFrameLen + `HMFS_WORD_ROUND) & `HMFS_WORD_MASK;

  // ==========================================================
  // Indirect access request
  // Busy write launches access
  assign csrIf.start  = cmdWr & wdm[`HMFS_BIT_BUSY];
  assign csrIf.isRead = wdm[`HMFS_BIT_DIR];
  assign csrIf.addr   = q.wStrb[0] ? wdm[7:0] : q.cmdAddr;
  assign csrIf.wdata  = q.csrWr;

  // ==========================================================
  // Next state
  always_comb begin
    logic [31:0] rdVal;
    logic        rdOk;
    logic        wrOk;
    rdVal = '0;
    rdOk  = 1'b1;
    wrOk  = 1'b1;
    d = q;
    if (s_axi_awvalid && !q.awHeld) begin
      d.awHeld = 1'b1;
      d.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !q.wHeld) begin
      d.wHeld = 1'b1;
      d.wData = s_axi_wdata;
      d.wStrb = s_axi_wstrb;
    end
    if (q.bValid && s_axi_bready) begin
      d.bValid = 1'b0;
    end
    if (q.rValid && s_axi_rready) begin
      d.rValid = 1'b0;
    end

    // Datapath counters
    // Byte occupancy of RX data
    d.rxUsed = q.rxUsed + (rxFrameDone ? rxAdd : 16'h0000)
             - (rxDataPop ? `HMFS_WORD_BYTES : 16'h0000)
             - (rxSkipDone ? rxSkipBytes : 16'h0000);
    d.tx_data_bytes_free = q.tx_data_bytes_free + (txDataRelease ? txReleaseBytes : 16'h0000)
             - (txDataPush ? `HMFS_WORD_BYTES : 16'h0000);
    if (rxSkipDone) begin
      d.skip = 1'b0;
    end
    if (rdDrop) begin
      d.drops = '0;
    end
    if (rxFrameDropped) begin
      d.drops = (rdDrop ? '0 : q.drops) + 32'h00000001;
    end
    // Done ends busy, captures read data
    if (csrIf.done) begin
      d.busy = 1'b0;
      if (q.cmdDir) begin
        d.csrRd = csrIf.rdata;
      end
    end

    // Register writes
    if (wrFire) begin
      d.awHeld = 1'b0;
      d.wHeld  = 1'b0;
      d.bValid = 1'b1;
      unique case (wrAddr)
        `HMFS_OFS_RXCTL: begin
          if (wdm[`HMFS_BIT_SKIP]) begin
            d.skip = 1'b1;
          end
        end
        `HMFS_OFS_CMD: begin
          if (cmdWr && q.wStrb[3]) begin
            d.cmdDir = wdm[`HMFS_BIT_DIR];
            d.busy   = wdm[`HMFS_BIT_BUSY];
          end
          if (cmdWr && q.wStrb[0]) begin
            d.cmdAddr = wdm[7:0];
          end
        end
        `HMFS_OFS_DATA: begin
          if (dataWr) begin
            d.csrWr = (q.csrWr & ~byteMask) | wdm;
          end
        end
        `HMFS_OFS_INTSTS: begin
          if (wdm[`HMFS_BIT_HALF]) begin
            d.halfSts = 1'b0;
          end
        end
        `HMFS_OFS_INTEN: begin
          if (q.wStrb[2]) begin
            d.halfEn = wdm[`HMFS_BIT_HALF];
          end
        end
        `HMFS_OFS_RXOCC, `HMFS_OFS_TXOCC, `HMFS_OFS_DROP: begin
          wrOk = 1'b1;
        end
        default: begin
          wrOk = 1'b0;
        end
      endcase
      d.bResp = wrOk ? `HMFS_RESP_OKAY : `HMFS_RESP_SLVERR;
    end
    if (rxFrameDropped && !rdDrop && q.drops == `HMFS_DROP_HALF) begin
      d.halfSts = 1'b1;
    end

    // Register reads
    if (rdFire) begin
      unique case (rdAddr)
        `HMFS_OFS_RXCTL: begin
          rdVal[`HMFS_BIT_SKIP] = q.skip;
        end
        `HMFS_OFS_RXOCC: begin
          rdVal = {8'h00, rxStatusWordsUsed, q.rxUsed};
        end
        `HMFS_OFS_TXOCC: begin
          rdVal = {8'h00, txStatusWordsUsed, q.tx_data_bytes_free};
        end
        `HMFS_OFS_DROP: begin
          rdVal = q.drops;
        end
        `HMFS_OFS_CMD: begin
          rdVal[`HMFS_BIT_BUSY] = q.busy;
          rdVal[`HMFS_BIT_DIR]  = q.cmdDir;
          rdVal[7:0]            = q.cmdAddr;
        end
        `HMFS_OFS_DATA: begin
          rdVal = q.cmdDir ? q.csrRd : q.csrWr;
        end
        `HMFS_OFS_INTSTS: begin
          rdVal[`HMFS_BIT_HALF] = q.halfSts;
        end
        `HMFS_OFS_INTEN: begin
          rdVal[`HMFS_BIT_HALF] = q.halfEn;
        end
        default: begin
          rdOk = 1'b0;
        end
      endcase
      d.rValid = 1'b1;
      d.rData  = rdVal;
      d.rResp  = rdOk ? `HMFS_RESP_OKAY : `HMFS_RESP_SLVERR;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      q <= RST_VAL;
    end else begin
      q <= d;
    end
  end

  assign rxSkipReq = q.skip;
  assign irq       = q.halfSts & q.halfEn;

  // ==========================================================
  // Indirect access engine
  hmfs_csr_engine u_engine (
    .clk_sys     (clk_sys),
    .rst         (rst),
    .csrIf       (csrIf.engine),
    .macCsrSel   (macCsrSel),
    .macCsrWe    (macCsrWe),
    .macCsrAddr  (macCsrAddr),
    .macCsrWdata (macCsrWdata),
    .macCsrRdata (macCsrRdata),
    .macCsrAck   (macCsrAck)
  );

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  skip_start_a: assert property (
    wrFire && wrAddr == `HMFS_OFS_RXCTL && wdm[`HMFS_BIT_SKIP]
    |=> rxSkipReq)
    else $error("skip not started");
  skip_hold_a: assert property (
    rxSkipReq && !rxSkipDone && !(wrFire && wrAddr == `HMFS_OFS_RXCTL)
    |=> rxSkipReq)
    else $error("skip dropped early");
  skip_clear_a: assert property (
    rxSkipDone && !(wrFire && wrAddr == `HMFS_OFS_RXCTL) |=> !rxSkipReq)
    else $error("skip not cleared");
  rx_status_a: assert property (
    rdFire && rdAddr == `HMFS_OFS_RXOCC
    |=> s_axi_rdata[23:16] == $past(rxStatusWordsUsed)
        && s_axi_rdata[31:24] == 8'h00)
    else $error("rx status words wrong");
  rx_used_a: assert property (
    rxFrameDone && !rxDataPop && !rxSkipDone
    |=> q.rxUsed == $past(q.rxUsed) + $past(rxAdd))
    else $error("rx used not added");
  tx_status_a: assert property (
    rdFire && rdAddr == `HMFS_OFS_TXOCC
    |=> s_axi_rdata[23:16] == $past(txStatusWordsUsed)
        && s_axi_rdata[15:0] == $past(q.tx_data_bytes_free))
    else $error("tx occupancy wrong");
  tx_free_a: assert property (
    txDataPush && !txDataRelease
    |=> q.tx_data_bytes_free == $past(q.tx_data_bytes_free) - `HMFS_WORD_BYTES)
    else $error("tx free not reduced");
  drop_count_a: assert property (
    rxFrameDropped && !rdDrop |=> q.drops == $past(q.drops) + 32'h00000001)
    else $error("drop count missed");
  drop_clear_a: assert property (
    rdDrop && !rxFrameDropped
    |=> q.drops == '0 && s_axi_rvalid && s_axi_rdata == $past(q.drops))
    else $error("drop read not cleared");
  half_flag_a: assert property (
    rxFrameDropped && !rdDrop && q.drops == `HMFS_DROP_HALF
    |=> q.halfSts ##0 (irq == q.halfEn))
    else $error("halfway flag missed");
  busy_start_a: assert property (
    csrIf.start |=> q.busy && macCsrSel && macCsrWe == !$past(csrIf.isRead))
    else $error("access not launched");
  busy_done_a: assert property (
    q.busy && csrIf.done |=> !q.busy)
    else $error("busy not cleared");
  csr_capture_a: assert property (
    csrIf.done && q.cmdDir |=> q.csrRd == $past(csrIf.rdata))
    else $error("read data not captured");
  cmd_frozen_a: assert property (
    q.busy |=> q.cmdAddr == $past(q.cmdAddr) && q.csrWr == $past(q.csrWr))
    else $error("command changed while busy");
  csr_addr_a: assert property (
    csrIf.start |=> macCsrAddr == $past(csrIf.addr))
    else $error("indirect address wrong");
  data_src_a: assert property (
    rdFire && rdAddr == `HMFS_OFS_DATA
    |=> s_axi_rdata == ($past(q.cmdDir) ? $past(q.csrRd) : $past(q.csrWr)))
    else $error("data register source wrong");
  rsvd_zero_a: assert property (
    rdFire && rdAddr == `HMFS_OFS_RXCTL |=> s_axi_rdata[30:0] == 31'h0)
    else $error("reserved bits not zero");

  // ==========================================================
  // Cover points
  skip_cov_c: cover property (rxSkipReq ##[1:20] !rxSkipReq);
  csr_read_c: cover property (csrIf.start && csrIf.isRead ##[1:20] csrIf.done);
  csr_write_c: cover property (
    csrIf.start && !csrIf.isRead ##[1:20] csrIf.done);
  half_irq_c: cover property ($rose(irq));
endmodule : hmfs_regs
`default_nettype wire

// ===== hmfs_mac_model.sv
// Purpose: Far-side model: MAC control registers and RX skip engine
// Assumes: Select held until ack; skip request held until done
// Notes:   Idle data lines show a changing pattern
`timescale 1ns/10ps
`default_nettype none
module hmfs_mac_model #(
  parameter int DLY = 12
) (
  input  wire logic        clk_sys,     // System clock
  input  wire logic        rst,         // Async reset
  input  wire logic        macCsrSel,   // Access active
  input  wire logic        macCsrWe,    // One for write
  input  wire logic [7:0]  macCsrAddr,  // Register index
  input  wire logic [31:0] macCsrWdata, // Write data
  output logic [31:0]      macCsrRdata, // Read data
  output logic             macCsrAck,   // Access done
  input  wire logic        rxSkipReq,   // Skip request
  output logic             rxSkipDone,  // Skip done
  output logic [15:0]      rxSkipBytes  // Bytes skipped
);
  logic [31:0] mem [256];
  int          cCnt;
  int          sCnt;
  logic [15:0] tick;

  assign macCsrRdata = macCsrAck ? mem[macCsrAddr] : {tick, ~tick};
  assign rxSkipBytes = rxSkipDone ? 16'h0008 : ~tick;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cCnt       <= 0;
      sCnt       <= 0;
      tick       <= 16'h0000;
      macCsrAck  <= 1'b0;
      rxSkipDone <= 1'b0;
    end else begin
      tick       <= tick + 16'h0001;
      macCsrAck  <= 1'b0;
      rxSkipDone <= 1'b0;
      cCnt       <= macCsrSel ? cCnt + 1 : 0;
      sCnt       <= (rxSkipReq && !rxSkipDone) ? sCnt + 1 : 0;
      if (macCsrSel && cCnt == DLY) begin
        macCsrAck <= 1'b1;
        cCnt      <= 0;
      end
      if (macCsrAck && macCsrWe) begin
        mem[macCsrAddr] <= macCsrWdata;
      end
      if (rxSkipReq && sCnt == DLY) begin
        rxSkipDone <= 1'b1;
        sCnt       <= 0;
      end
    end
  end
endmodule : hmfs_mac_model
`default_nettype wire

// ===== tb.sv
// Purpose: Self-checking bench of the FIFO status register bank
// Assumes: AXI4-Lite master tasks, far side from hmfs_mac_model
// Notes:   Halfway count is out of reach in a short run
`timescale 1ns/10ps
`include "hmfs_map.svh"
`default_nettype none
module tb;
  logic        clk_sys, rst, awvalid, awready, wvalid, wready, bvalid;
  logic        bready, arvalid, arready, rvalid, rready, irq;
  logic [7:0]  awaddr, araddr, mAddr;
  logic [31:0] wdata, rdata, mWd, mRd, d;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, r;
  logic        fDone, pop, skReq, skDone, push, rel, drop, sel, we, ack;
  logic [15:0] fLen, skBytes, relBytes;
  logic [7:0]  rxSw, txSw;
  int          err_count, n_checks;

  hmfs_regs hmfs_regs_inst (.clk_sys(clk_sys), .rst(rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .rxFrameDone(fDone),
    .rxFrameLen(fLen), .rxDataPop(pop), .rxSkipReq(skReq),
    .rxSkipDone(skDone), .rxSkipBytes(skBytes), .rxStatusWordsUsed(rxSw),
    .txStatusWordsUsed(txSw), .txDataPush(push), .txDataRelease(rel),
    .txReleaseBytes(relBytes), .rxFrameDropped(drop), .macCsrSel(sel),
    .macCsrWe(we), .macCsrAddr(mAddr), .macCsrWdata(mWd),
    .macCsrRdata(mRd), .macCsrAck(ack), .irq(irq));

  hmfs_mac_model hmfs_mac_model_inst (.clk_sys(clk_sys), .rst(rst),
    .macCsrSel(sel), .macCsrWe(we), .macCsrAddr(mAddr), .macCsrWdata(mWd),
    .macCsrRdata(mRd), .macCsrAck(ack), .rxSkipReq(skReq),
    .rxSkipDone(skDone), .rxSkipBytes(skBytes));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      err_count++;
      $display("FAIL %0t: saw %h expected %h", $time, s, e);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (awvalid && awready) begin
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        wvalid <= 1'b0;
      end
    end while (!(bvalid && bready));
    r = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (arvalid && arready) begin
        arvalid <= 1'b0;
      end
    end while (!(rvalid && rready));
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd

  // Read until bit 31 clears, bounded
  task automatic poll(input logic [7:0] a);
    int n;
    n = 0;
    do begin
      rd(a);
      n++;
    end while (d[31] !== 1'b0 && n < 40);
    chk({31'h0, d[31]}, 32'h0);
  endtask : poll

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : wrap_up

  initial begin
    #200us;
    err_count++;
    wrap_up();
  end

  initial begin
    {awvalid, wvalid, bready, arvalid, rready, fDone, pop, push} = '0;
    {rel, drop} = '0;
    {awaddr, araddr} = '0;
    {wdata, fLen, relBytes} = '0;
    wstrb = 4'hF;
    rxSw = 8'h05;
    txSw = 8'h0A;
    err_count = 0;
    n_checks = 0;
    rst = 1'b1;
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    rd(`HMFS_OFS_RXOCC);
    chk(d, 32'h0005_0000);
    rd(`HMFS_OFS_TXOCC);
    chk(d, 32'h000A_1200);
    rd(`HMFS_OFS_RXCTL);
    chk(d, 32'h0000_0000);
    wr(`HMFS_OFS_RXOCC, 32'hFFFF_FFFF);
    chk({30'h0, r}, {30'h0, `HMFS_RESP_OKAY});
    rd(`HMFS_OFS_RXOCC);
    chk(d, 32'h0005_0000);
    wr(8'h10, 32'hFFFF_FFFF);
    chk({30'h0, r}, {30'h0, `HMFS_RESP_SLVERR});
    rd(8'h10);
    chk({d[31:2], r}, {30'h0, `HMFS_RESP_SLVERR});
    // Frames of 5 and 8 bytes, then one word popped
    @(posedge clk_sys);
    fLen <= 16'h0005;
    fDone <= 1'b1;
    @(posedge clk_sys);
    fLen <= 16'h0008;
    @(posedge clk_sys);
    fDone <= 1'b0;
    pop <= 1'b1;
    @(posedge clk_sys);
    pop <= 1'b0;
    rd(`HMFS_OFS_RXOCC);
    chk(d, 32'h0005_000C);
    // Two words, well under free space
    @(posedge clk_sys);
    push <= 1'b1;
    repeat (2) @(posedge clk_sys);
    push <= 1'b0;
    rd(`HMFS_OFS_TXOCC);
    chk(d, 32'h000A_11F8);
    @(posedge clk_sys);
    rel <= 1'b1;
    relBytes <= 16'h0008;
    txSw <= 8'h03;
    @(posedge clk_sys);
    rel <= 1'b0;
    rd(`HMFS_OFS_TXOCC);
    chk(d, 32'h0003_1200);
    wr(`HMFS_OFS_RXCTL, 32'hFFFF_FFFF);
    rd(`HMFS_OFS_RXCTL);
    chk(d, 32'h8000_0000);
    poll(`HMFS_OFS_RXCTL);
    rxSw <= 8'h07;
    rd(`HMFS_OFS_RXOCC);
    chk(d, 32'h0007_0004);
    @(posedge clk_sys);
    drop <= 1'b1;
    repeat (3) @(posedge clk_sys);
    drop <= 1'b0;
    rd(`HMFS_OFS_DROP);
    chk(d, 32'h0000_0003);
    rd(`HMFS_OFS_DROP);
    chk(d, 32'h0000_0000);
    wr(`HMFS_OFS_INTEN, 32'hFFFF_FFFF);
    rd(`HMFS_OFS_INTEN);
    chk(d, 32'h0080_0000);
    wr(`HMFS_OFS_INTSTS, 32'h0080_0000);
    rd(`HMFS_OFS_INTSTS);
    chk(d, 32'h0000_0000);
    chk({31'h0, irq}, 32'h0000_0000);
    wr(`HMFS_OFS_DATA, 32'h1234_ABCD);
    rd(`HMFS_OFS_DATA);
    chk(d, 32'h1234_ABCD);
    // Command left alone until busy clears
    wr(`HMFS_OFS_CMD, 32'h8000_0042);
    rd(`HMFS_OFS_CMD);
    chk(d, 32'h8000_0042);
    poll(`HMFS_OFS_CMD);
    chk(hmfs_mac_model_inst.mem[8'h42], 32'h1234_ABCD);
    // Load register 07 through an indirect write
    wr(`HMFS_OFS_DATA, 32'h0BAD_F00D);
    wr(`HMFS_OFS_CMD, 32'h8000_0007);
    poll(`HMFS_OFS_CMD);
    wr(`HMFS_OFS_DATA, 32'h0000_0000);
    wr(`HMFS_OFS_CMD, 32'hFFFF_FF07);
    rd(`HMFS_OFS_CMD);
    chk(d, 32'hC000_0007);
    poll(`HMFS_OFS_CMD);
    rd(`HMFS_OFS_DATA);
    chk(d, 32'h0BAD_F00D);
    wrap_up();
  end
endmodule : tb
`default_nettype wire
